// file: pwmtc_pkg.sv
package pwmtc_pkg;

    // Three-level strap codes as delivered by the pad sense logic
    typedef enum logic [1:0] {
        PWMTC_ONESHOT = 2'b00,
        PWMTC_CONT    = 2'b01,
        PWMTC_CHAIN   = 2'b10
    } pwmtc_mode_t;

    typedef enum logic [1:0] {
        PWMTC_QUARTER     = 2'b00,
        PWMTC_NOMINAL     = 2'b01,
        PWMTC_DOUBLE_HIGH = 2'b10
    } pwmtc_rate_t;

    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned CLK_KHZ = 125000;

    // Nominal high period
    localparam int unsigned TH_NOM_MS  = 40;
    localparam int unsigned TH_NOM_CYC = TH_NOM_MS * CLK_KHZ;

    // Start pulse emitted downstream, typical width
    localparam int unsigned START_OUT_NS  = 17000;
    localparam int unsigned START_OUT_CYC = (START_OUT_NS * CLK_MHZ + 999) / 1000;

    // Start pulse issued by the controller, must stay below the maximum
    localparam int unsigned START_MAX_NS  = 25000;
    localparam int unsigned START_MAX_CYC = (START_MAX_NS * CLK_MHZ) / 1000;
    localparam int unsigned START_REQ_NS  = 10000;
    localparam int unsigned START_REQ_CYC = (START_REQ_NS * CLK_MHZ) / 1000;

    // Highs shorter than this are start pulses; also the chain buffer delay
    localparam int unsigned DET_US  = 1000;
    localparam int unsigned DET_CYC = DET_US * CLK_MHZ;

    // Chain input held high this long powers the part down
    localparam int unsigned PD_MS  = 300;
    localparam int unsigned PD_CYC = PD_MS * CLK_KHZ;

    // One-shot request: controller pulls the output line low this long
    localparam int unsigned PULL_NS  = 2000;
    localparam int unsigned PULL_CYC = (PULL_NS * CLK_MHZ) / 1000;

    // Edges after reset release before the straps are caught
    localparam logic [1:0] BOOT_WAIT = 2'h3;

    // Decode: temp = 421 - 751 * TH / TL (divide coefficient by 8 at double high)
    localparam int unsigned TEMP_OFS      = 421;
    localparam int unsigned TEMP_COEF     = 751;
    localparam int unsigned FRAC_BITS     = 8;
    localparam int unsigned TEMP_OFS_Q8   = TEMP_OFS << FRAC_BITS;
    localparam logic [6:0]  DIV_STEPS     = 7'h40;

endpackage

// file: pwmtc_if.sv
`timescale 1ns/1ps
interface pwmtc_if;
    logic pwm_line;                 // Resolved output line, pulled up
    logic dev_out;                  // Device drive value
    logic dev_out_oe_n;             // Device drives when low
    logic host_pull_oe_n;           // Controller pulls low when low
    logic rate_select_chain_input;  // Rate strap level or chain input
    logic rate_select_float;        // Rate strap left floating

    assign pwm_line = (dev_out_oe_n | dev_out) & host_pull_oe_n;

    modport device (
        input  pwm_line,
        input  rate_select_chain_input,
        input  rate_select_float,
        output dev_out,
        output dev_out_oe_n
    );

    modport host (
        input  pwm_line,
        output host_pull_oe_n,
        output rate_select_chain_input,
        output rate_select_float
    );
endinterface

// file: pwmtc_device.sv
`timescale 1ns/1ps
module pwmtc_device #(
    parameter int unsigned TH_CYC  = pwmtc_pkg::TH_NOM_CYC,
    parameter int unsigned DET_CYC = pwmtc_pkg::DET_CYC,
    parameter int unsigned PD_CYC  = pwmtc_pkg::PD_CYC
) (
    input  wire logic              clock,             // 125 MHz clock
    input  wire logic              reset,             // Power-up reset, async
    input  wire logic [1:0]        mode_select_input, // Three-level mode strap code
    input  wire logic [31:0]       sensor_tl_cycles,  // Nominal low period from sensor
    output pwmtc_pkg::pwmtc_mode_t active_mode,       // Mode caught at power-up
    output logic                   powered_down,      // Chain idle power-down
    pwmtc_if.device                link               // Link pins
);
    import pwmtc_pkg::*;

    typedef enum logic [2:0] {
        D_BOOT  = 3'b000,
        D_IDLE  = 3'b001,
        D_HIGH  = 3'b010,
        D_LOW   = 3'b011,
        D_START = 3'b100,
        D_PASS  = 3'b101
    } pwmtc_dstate_t;

    // Period scaling for the caught rate; never shorter than one cycle
    function automatic logic [31:0] scale_period(input pwmtc_rate_t rate,
                                                 input logic [31:0] val,
                                                 input logic        is_high);
        logic [31:0] r;
        r = val;
        case (rate)
            PWMTC_QUARTER:     r = val >> 2;
            PWMTC_DOUBLE_HIGH: r = is_high ? {val[30:0], 1'b0} : (val >> 2);
            default:           r = val;
        endcase
        return (r == 32'h0) ? 32'h1 : r;
    endfunction

    pwmtc_dstate_t state_r, state_nxt;
    pwmtc_mode_t   mode_r, mode_nxt;
    pwmtc_rate_t   rate_r, rate_nxt;
    logic [4:0]    meta_r, sync_r;
    logic [1:0]    boot_r, boot_nxt;
    logic [31:0]   cnt_r, cnt_nxt;
    logic [31:0]   run_r, run_nxt;
    logic          chain_d_r;
    logic          armed_r, armed_nxt;
    logic          out_r, out_nxt;
    logic          oe_n_r, oe_n_nxt;
    logic          pd_r, pd_nxt;

    wire         line_s = sync_r[0];
    wire         chain_s = sync_r[1];
    wire         flt_s = sync_r[2];
    wire [1:0]   mode_s = sync_r[4:3];

    wire [31:0]  th_len = scale_period(rate_r, TH_CYC, 1'b1);
    wire [31:0]  tl_len = scale_period(rate_r, sensor_tl_cycles, 1'b0);
    wire         th_done = (cnt_r >= th_len - 32'h1);
    wire         tl_done = (cnt_r >= tl_len - 32'h1);
    wire         st_done = (cnt_r >= START_OUT_CYC - 32'h1);

    wire         edge_w = chain_s ^ chain_d_r;
    wire         short_w = (run_r < DET_CYC - 32'h1);
    wire         start_w = edge_w & ~chain_s & short_w;
    wire         settled_w = ~edge_w & ~short_w;
    wire         pd_hit = chain_s & (run_r >= PD_CYC - 32'h1);
    wire [31:0]  run_inc = (run_r == 32'hFFFFFFFF) ? run_r : run_r + 32'h1;

    wire pwmtc_mode_t mode_dec = (mode_s == 2'b11) ? PWMTC_CONT : pwmtc_mode_t'(mode_s);
    wire pwmtc_rate_t rate_dec = flt_s   ? PWMTC_NOMINAL :
                                 chain_s ? PWMTC_DOUBLE_HIGH : PWMTC_QUARTER;

    always_comb begin
        state_nxt = state_r;
        mode_nxt  = mode_r;
        rate_nxt  = rate_r;
        boot_nxt  = boot_r;
        cnt_nxt   = cnt_r + 32'h1;
        run_nxt   = edge_w ? 32'h0 : run_inc;
        armed_nxt = armed_r;
        out_nxt   = out_r;
        oe_n_nxt  = oe_n_r;
        pd_nxt    = pd_r;
        case (state_r)
            D_BOOT: begin
                boot_nxt = boot_r + 2'h1;
                if (boot_r == BOOT_WAIT) begin
                    mode_nxt = mode_dec;
                    rate_nxt = (mode_dec == PWMTC_CHAIN) ? PWMTC_NOMINAL
                                                         : rate_dec;
                    cnt_nxt  = 32'h0;
                    run_nxt  = 32'h0;
                    case (mode_dec)
                        PWMTC_ONESHOT: begin
                            state_nxt = D_IDLE;
                        end
                        PWMTC_CHAIN: begin
                            // A level held since power-up is idle, never a start pulse
                            state_nxt = D_PASS;
                            oe_n_nxt  = 1'b0;
                            out_nxt   = chain_s;
                            run_nxt   = DET_CYC;
                        end
                        default: begin
                            state_nxt = D_HIGH;
                            oe_n_nxt  = 1'b0;
                            out_nxt   = 1'b1;
                        end
                    endcase
                end
            end
            D_IDLE: begin
                oe_n_nxt = 1'b1;
                if (!line_s) begin
                    armed_nxt = 1'b1;
                end else if (armed_r) begin
                    armed_nxt = 1'b0;
                    state_nxt = D_HIGH;
                    cnt_nxt   = 32'h0;
                    oe_n_nxt  = 1'b0;
                    out_nxt   = 1'b1;
                end
            end
            D_HIGH: begin
                if (th_done) begin
                    state_nxt = D_LOW;
                    cnt_nxt   = 32'h0;
                    out_nxt   = 1'b0;
                end
            end
            D_LOW: begin
                if (tl_done) begin
                    cnt_nxt = 32'h0;
                    out_nxt = 1'b1;
                    case (mode_r)
                        PWMTC_ONESHOT: begin
                            state_nxt = D_IDLE;
                            oe_n_nxt  = 1'b1;
                        end
                        PWMTC_CHAIN: begin
                            state_nxt = D_START;
                        end
                        default: begin
                            state_nxt = D_HIGH;
                        end
                    endcase
                end
            end
            D_START: begin
                if (st_done) begin
                    state_nxt = D_PASS;
                    out_nxt   = 1'b0;
                    run_nxt   = 32'h0;
                end
            end
            D_PASS: begin
                // Delayed copy of the input; highs shorter than the delay are dropped
                if (settled_w) begin
                    out_nxt = chain_s;
                end
                if (pd_hit) begin
                    pd_nxt = 1'b1;
                end
                if (start_w) begin
                    state_nxt = D_HIGH;
                    cnt_nxt   = 32'h0;
                    out_nxt   = 1'b1;
                    pd_nxt    = 1'b0;
                end
            end
            default: begin
                state_nxt = D_BOOT;
                boot_nxt  = 2'h0;
            end
        endcase
    end

    // Rate strap passes the synchroniser but is only read in D_BOOT
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            meta_r <= 5'h0;
            sync_r <= 5'h0;
        end else begin
            meta_r <= {mode_select_input, link.rate_select_float,
                       link.rate_select_chain_input, link.pwm_line};
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_r   <= D_BOOT;
            mode_r    <= PWMTC_CONT;
            rate_r    <= PWMTC_NOMINAL;
            boot_r    <= 2'h0;
            cnt_r     <= 32'h0;
            run_r     <= 32'h0;
            chain_d_r <= 1'b0;
            armed_r   <= 1'b0;
            out_r     <= 1'b1;
            oe_n_r    <= 1'b1;
            pd_r      <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            mode_r    <= mode_nxt;
            rate_r    <= rate_nxt;
            boot_r    <= boot_nxt;
            cnt_r     <= cnt_nxt;
            run_r     <= run_nxt;
            chain_d_r <= chain_s;
            armed_r   <= armed_nxt;
            out_r     <= out_nxt;
            oe_n_r    <= oe_n_nxt;
            pd_r      <= pd_nxt;
        end
    end

    assign link.dev_out      = out_r;
    assign link.dev_out_oe_n = oe_n_r;
    assign active_mode       = mode_r;
    assign powered_down      = pd_r;

endmodule

// file: pwmtc_host.sv
`timescale 1ns/1ps
module pwmtc_host #(
    parameter int unsigned DET_CYC = pwmtc_pkg::DET_CYC,
    parameter int unsigned N_DEV   = 2
) (
    input  wire logic               clock,       // 125 MHz clock
    input  wire logic               reset,       // Async reset
    input  pwmtc_pkg::pwmtc_mode_t  mode_cfg,    // Mode the devices are strapped to
    input  pwmtc_pkg::pwmtc_rate_t  rate_cfg,    // Rate strap driven to the device
    input  wire logic               start_req,   // One-cycle measurement request
    output logic                    busy,        // Request sequence running
    output logic [31:0]             th_cycles,   // Last high period
    output logic [31:0]             tl_cycles,   // Last low period
    output logic signed [31:0]      temp_q8,     // Temperature, 8 fraction bits
    output logic                    meas_valid,  // One-cycle result strobe
    output logic [7:0]              starts_seen, // Start pulses since request
    pwmtc_if.host                   link         // Link pins
);
    import pwmtc_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_PULL = 3'b001,
        H_WAIT = 3'b010,
        H_PRE  = 3'b011,
        H_STRT = 3'b100,
        H_HOLD = 3'b101
    } pwmtc_hstate_t;

    pwmtc_hstate_t state_r, state_nxt;
    logic [31:0]   cnt_r, cnt_nxt;
    logic [31:0]   run_r, th_r, tl_r;
    logic          meta_r, line_s, line_d_r;
    logic          rise_ok_r, th_ok_r, valid_r, busy_r;
    logic          chain_r, chain_nxt, pull_n_r, pull_n_nxt;
    logic [7:0]    starts_r;
    logic [6:0]    div_cnt_r;
    logic [63:0]   num_r, den_r, rem_r, quo_r;
    logic signed [31:0] temp_r;

    wire         go_w = start_req & (state_r == H_IDLE);
    wire         rise_w = line_s & ~line_d_r;
    wire         fall_w = ~line_s & line_d_r;
    wire         short_w = (run_r < DET_CYC - 32'h1);
    wire [31:0]  len_w = run_r + 32'h1;
    wire         hi_coef = (mode_cfg != PWMTC_CHAIN) && (rate_cfg == PWMTC_DOUBLE_HIGH);
    wire [63:0]  num_w = (64'(th_r) * 64'(TEMP_COEF)) << FRAC_BITS;
    wire [63:0]  den_w = hi_coef ? {29'h0, len_w, 3'h0} : {32'h0, len_w};
    wire [63:0]  rem_sh = {rem_r[62:0], num_r[63]};
    wire         ge_w = (rem_sh >= den_r);
    wire [63:0]  quo_w = {quo_r[62:0], ge_w};
    wire         div_last = (div_cnt_r == 7'h1);
    wire         strap_lvl = (rate_cfg == PWMTC_DOUBLE_HIGH);
    wire         step_done = (cnt_r >= START_REQ_CYC - 32'h1);
    // Preamble low must outlast the device buffer delay to show on the line
    wire         pre_done = (cnt_r >= DET_CYC + START_REQ_CYC - 32'h1);

    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r + 32'h1;
        chain_nxt  = (mode_cfg == PWMTC_CHAIN) ? 1'b1 : strap_lvl;
        pull_n_nxt = 1'b1;
        case (state_r)
            H_IDLE: begin
                cnt_nxt = 32'h0;
                if (start_req && mode_cfg == PWMTC_ONESHOT) begin
                    state_nxt  = H_PULL;
                    pull_n_nxt = 1'b0;
                end else if (start_req && mode_cfg == PWMTC_CHAIN) begin
                    state_nxt = H_PRE;
                    chain_nxt = 1'b0;
                end
            end
            H_PULL: begin
                pull_n_nxt = 1'b0;
                if (cnt_r >= PULL_CYC - 32'h1) begin
                    state_nxt  = H_WAIT;
                    pull_n_nxt = 1'b1;
                end
            end
            H_WAIT: begin
                if (valid_r) begin
                    state_nxt = H_IDLE;
                end
            end
            H_PRE: begin
                chain_nxt = 1'b0;
                if (pre_done) begin
                    state_nxt = H_STRT;
                    cnt_nxt   = 32'h0;
                    chain_nxt = 1'b1;
                end
            end
            H_STRT: begin
                chain_nxt = 1'b1;
                if (step_done) begin
                    state_nxt = H_HOLD;
                    chain_nxt = 1'b0;
                end
            end
            H_HOLD: begin
                chain_nxt = 1'b0;
                if (starts_r >= N_DEV[7:0]) begin
                    state_nxt = H_IDLE;
                    chain_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_r  <= H_IDLE;
            cnt_r    <= 32'h0;
            chain_r  <= 1'b1;
            pull_n_r <= 1'b1;
            busy_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            chain_r  <= chain_nxt;
            pull_n_r <= pull_n_nxt;
            busy_r   <= (state_nxt != H_IDLE);
        end
    end

    // Both periods timed on this one clock so the ratio is clock-free
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            meta_r    <= 1'b1;
            line_s    <= 1'b1;
            line_d_r  <= 1'b1;
            run_r     <= 32'h0;
            rise_ok_r <= 1'b0;
            th_ok_r   <= 1'b0;
            th_r      <= 32'h0;
            tl_r      <= 32'h0;
            starts_r  <= 8'h0;
            div_cnt_r <= 7'h0;
        end else begin
            meta_r   <= link.pwm_line;
            line_s   <= meta_r;
            line_d_r <= line_s;
            run_r    <= (rise_w | fall_w) ? 32'h0 : run_r + 32'h1;
            if (go_w) begin
                rise_ok_r <= 1'b0;
                th_ok_r   <= 1'b0;
                starts_r  <= 8'h0;
            end else if (fall_w && short_w && rise_ok_r) begin
                starts_r <= starts_r + 8'h1;
            end else if (fall_w && rise_ok_r) begin
                th_r    <= len_w;
                th_ok_r <= 1'b1;
            end else if (rise_w) begin
                rise_ok_r <= 1'b1;
                if (th_ok_r) begin
                    tl_r      <= len_w;
                    th_ok_r   <= 1'b0;
                    div_cnt_r <= DIV_STEPS;
                end
            end
            if (div_cnt_r != 7'h0 && !(rise_w && th_ok_r && !go_w)) begin
                div_cnt_r <= div_cnt_r - 7'h1;
            end
        end
    end

    // Restoring divider: one quotient bit per cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            num_r   <= 64'h0;
            den_r   <= 64'h1;
            rem_r   <= 64'h0;
            quo_r   <= 64'h0;
            temp_r  <= 32'sh0;
            valid_r <= 1'b0;
        end else begin
            valid_r <= 1'b0;
            if (rise_w && th_ok_r && !go_w) begin
                num_r <= num_w;
                den_r <= den_w;
                rem_r <= 64'h0;
                quo_r <= 64'h0;
            end else if (div_cnt_r != 7'h0) begin
                num_r <= {num_r[62:0], 1'b0};
                rem_r <= ge_w ? rem_sh - den_r : rem_sh;
                quo_r <= quo_w;
                if (div_last) begin
                    temp_r  <= $signed(TEMP_OFS_Q8) - $signed(quo_w[31:0]);
                    valid_r <= 1'b1;
                end
            end
        end
    end

    assign link.rate_select_chain_input = chain_r;
    assign link.rate_select_float = (mode_cfg != PWMTC_CHAIN) && (rate_cfg == PWMTC_NOMINAL);
    assign link.host_pull_oe_n = pull_n_r;
    assign busy        = busy_r;
    assign th_cycles   = th_r;
    assign tl_cycles   = tl_r;
    assign temp_q8     = temp_r;
    assign meas_valid  = valid_r;
    assign starts_seen = starts_r;

endmodule

// file: pwmtc_monitor.sv
`timescale 1ns/1ps
module pwmtc_monitor #(
    parameter int unsigned TH_CYC = pwmtc_pkg::TH_NOM_CYC
) (
    input wire logic clock,                  // Clock
    input wire logic reset,                  // Async reset
    input wire logic pwm_line,               // Resolved line
    input wire logic dev_out,                // Device level
    input wire logic dev_out_oe_n,           // Device enable
    input wire logic host_pull_oe_n,         // Host pull enable
    input wire logic rate_select_chain_input // Chain input
);
    import pwmtc_pkg::*;
    logic        line_d_r, line_lo_r, cin_d_r, cin_lo_r, started_r;
    logic [31:0] line_hi_r, cin_hi_r, cin_lo_cnt_r, pull_cnt_r;
    // Edges count only once a low was seen since reset
    wire line_fall = line_d_r & ~pwm_line & line_lo_r;
    wire cin_fall  = cin_d_r & ~rate_select_chain_input & cin_lo_r;
    wire cin_rise  = ~cin_d_r & rate_select_chain_input & started_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            {line_d_r, line_lo_r, cin_d_r, cin_lo_r, started_r} <= '0;
            {line_hi_r, cin_hi_r, cin_lo_cnt_r, pull_cnt_r} <= '0;
        end else begin
            line_d_r <= pwm_line;
            line_lo_r <= line_lo_r | ~pwm_line;
            cin_d_r <= rate_select_chain_input;
            cin_lo_r <= cin_lo_r | ~rate_select_chain_input;
            started_r <= started_r | cin_fall;
            line_hi_r <= pwm_line ? line_hi_r + 32'h1 : '0;
            cin_hi_r <= rate_select_chain_input ? cin_hi_r + 32'h1 : '0;
            cin_lo_cnt_r <= rate_select_chain_input ? '0 : cin_lo_cnt_r + 32'h1;
            pull_cnt_r <= host_pull_oe_n ? '0 : pull_cnt_r + 32'h1;
        end
    end
    pull_len_a: assert property ($rose(host_pull_oe_n) |-> pull_cnt_r == PULL_CYC)
        else $error("host pull width wrong");
    no_fight_a: assert property (!host_pull_oe_n |-> dev_out_oe_n)
        else $error("device drives during pull");
    shot_resp_a: assert property ($rose(host_pull_oe_n) |-> ##[1:8] !dev_out_oe_n && dev_out)
        else $error("no answer to request");
    release_a: assert property ($rose(dev_out_oe_n) |-> dev_out && pwm_line)
        else $error("release not high");
    // High runs may include a few cycles of pull-up before the device drives
    high_len_a: assert property (line_fall |-> line_hi_r - TH_CYC / 4 < 8 ||
        line_hi_r - 2 * TH_CYC < 8 || line_hi_r - TH_CYC < 8 || line_hi_r - START_OUT_CYC < 8)
        else $error("high period length wrong");
    chain_start_a: assert property (cin_fall |-> cin_hi_r < START_MAX_CYC)
        else $error("start pulse too wide");
    chain_resp_a: assert property (cin_fall |-> ##[1:6] !dev_out_oe_n && dev_out)
        else $error("no output after start");
    chain_hold_a: assert property (cin_rise |-> cin_lo_cnt_r > TH_CYC)
        else $error("chain input released early");
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pwmtc_pkg::*;
    localparam int unsigned TH = 10400;
    localparam int unsigned TL = 19760;
    logic               clock = 1'b0;
    logic               reset = 1'b1;
    logic               start_req = 1'b0;
    pwmtc_mode_t        mode_cfg = PWMTC_ONESHOT;
    pwmtc_rate_t        rate_cfg = PWMTC_QUARTER;
    pwmtc_mode_t        act;
    logic               busy, meas_valid, powered_down;
    logic [31:0]        th, tl;
    logic signed [31:0] temp;
    logic [7:0]         starts;
    int                 miscompares = 0;
    int                 cmp_count = 0;
    pwmtc_if link ();
    always #4 clock = ~clock;
    pwmtc_device #(.TH_CYC(TH), .DET_CYC(2500), .PD_CYC(5000)) pwmtc_device_inst (
        .clock(clock), .reset(reset), .mode_select_input(mode_cfg), .sensor_tl_cycles(TL),
        .active_mode(act), .powered_down(powered_down), .link(link));
    pwmtc_host #(.DET_CYC(2500), .N_DEV(1)) pwmtc_host_inst (
        .clock(clock), .reset(reset), .mode_cfg(mode_cfg), .rate_cfg(rate_cfg),
        .start_req(start_req), .busy(busy), .th_cycles(th), .tl_cycles(tl), .temp_q8(temp),
        .meas_valid(meas_valid), .starts_seen(starts), .link(link));
    pwmtc_monitor #(.TH_CYC(TH)) pwmtc_monitor_inst (
        .clock(clock), .reset(reset), .pwm_line(link.pwm_line), .dev_out(link.dev_out),
        .dev_out_oe_n(link.dev_out_oe_n), .host_pull_oe_n(link.host_pull_oe_n),
        .rate_select_chain_input(link.rate_select_chain_input));
    function automatic logic [31:0] exp_temp(input longint t_h, input longint t_l);
        return 32'(longint'(TEMP_OFS_Q8) - longint'(TEMP_COEF) * 256 * t_h / t_l);
    endfunction
    task automatic print_verdict();
        $display("Comparisons %0d, miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
        cmp_count++;
        if ((^got === 1'bx) || (got > exp + tol) || (got + tol < exp)) begin
            miscompares++;
            $display("Error %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask
    // Waits for result (0), idle (1) or power-down (2)
    task automatic wait_for(input int w, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(negedge clock);
            if ((w == 0 && meas_valid === 1'b1) || (w == 1 && busy === 1'b0) ||
                (w == 2 && powered_down === 1'b1))
                break;
        end
        if (i == n) begin
            miscompares++;
            $display("Error %0t: wait %0d timed out", $time, w);
            print_verdict();
        end
    endtask
    task automatic boot(input pwmtc_mode_t m, input pwmtc_rate_t r);
        reset <= 1'b1;
        mode_cfg <= m;
        rate_cfg <= r;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        repeat (8) @(posedge clock);
        chk(act, m, 0);
    endtask
    task automatic request(input int n);
        @(posedge clock);
        start_req <= 1'b1;
        @(posedge clock);
        start_req <= 1'b0;
        wait_for(0, n);
    endtask
    task automatic t_rate_locked();
        boot(PWMTC_ONESHOT, PWMTC_QUARTER);
        rate_cfg <= PWMTC_DOUBLE_HIGH;
        request(40000);
        chk(th, TH / 4, 8);
        chk(tl, TL / 4, 2);
        wait_for(1, 4);
        chk(busy, 0, 0);
    endtask
    task automatic t_double_high();
        boot(PWMTC_ONESHOT, PWMTC_DOUBLE_HIGH);
        request(60000);
        chk(th, 2 * TH, 8);
        chk(tl, TL / 4, 2);
        chk(temp, exp_temp(2 * TH, TL / 4 * 8), 160);
    endtask
    task automatic t_continuous();
        boot(PWMTC_CONT, PWMTC_QUARTER);
        request(20000);
        chk(th, TH / 4, 2);
        chk(tl, TL / 4, 2);
        chk(temp, exp_temp(TH / 4, TL / 4), 160);
    endtask
    task automatic t_chain();
        boot(PWMTC_CHAIN, PWMTC_QUARTER);
        request(60000);
        chk(th, TH, 8);
        chk(tl, TL, 2);
        chk(temp, exp_temp(TH, TL), 160);
        wait_for(1, 10000);
        chk(starts, 1, 0);
        wait_for(2, 8000);
        chk(powered_down, 1, 0);
    endtask
    initial begin
        t_rate_locked();
        t_double_high();
        t_continuous();
        t_chain();
        print_verdict();
    end
endmodule
